// file: ssf_ctrl.sv
// Supervisory, fail-safe and watchdog control of a dual power switch
//
// Overview of operation
// - Reset clears configuration, faults; enters sleep
// - Reset release starts the watchdog counting
// - Watchdog enabled only while wake is high
// - Any fault pulls open-drain fault flag low
// - Individual fault causes shifted out serially
// - Timeout drives outputs per fail-safe selector
// - Grounded selector disables watchdog and fail-safe
// - Current sense follows serially selected channel
// - Current sense tri-stated when configured so
// - Direct inputs switch their matching outputs
// - Direct input behaviour reconfigurable by commands
// - Two-phase over-current blanking, high then low
// - Commands are 8 bits, MSB first, rising edge
// - Serial output driven only while selected
// - Sleep with outputs off while reset is low, whatever wake is
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_ctrl
   import ssf_pkg::*;
#(
   parameter int unsigned P_OCL_CYC0 = `SSF_T_OCL0_US * (`SSF_CLK_KHZ / 1000),
   parameter int unsigned P_OCL_CYC1 = `SSF_T_OCL1_US * (`SSF_CLK_KHZ / 1000),
   parameter int unsigned P_OCL_CYC2 = `SSF_T_OCL2_US * (`SSF_CLK_KHZ / 1000),
   parameter int unsigned P_OCL_CYC3 = `SSF_T_OCL3_US * (`SSF_CLK_KHZ / 1000),
   parameter int unsigned P_WD_CYC0 = `SSF_T_WD0_MS * `SSF_CLK_KHZ,
   parameter int unsigned P_WD_CYC1 = `SSF_T_WD1_MS * `SSF_CLK_KHZ,
   parameter int unsigned P_WD_CYC2 = `SSF_T_WD2_MS * `SSF_CLK_KHZ,
   parameter int unsigned P_WD_CYC3 = `SSF_T_WD3_MS * `SSF_CLK_KHZ
)
(
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Serial link
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   // Control pins
   input wire logic i_wake,
   input wire logic [1:0] i_direct_control_in,
   input wire logic [1:0] i_failsafe_selector_in,
   // Fault detectors
   input wire logic [1:0] i_high_trip_level,
   input wire logic [1:0] i_low_trip_level,
   input wire logic [1:0] i_over_temp,
   input wire logic i_supply_fault,
   // Open-drain fault flag
   input wire logic i_fault_flag_n_in,
   output logic o_fault_flag_n_out,
   output logic o_fault_flag_n_oe,
   // Power outputs and current sense
   output logic o_power_output_zero,
   output logic o_power_output_one,
   output logic o_current_sense_sel,
   output logic o_current_sense_oe,
   // Mode
   output logic o_sleep,
   output logic o_failsafe
);

   ssf_state_t r;
   ssf_state_t n;

   logic [7:0] word;
   logic word_tgl;
   logic [14:0] pins;
   logic [14:0] diff;
   logic wake;
   logic [1:0] failsafe_selector_in;
   logic [1:0] dir_in;
   logic [1:0] och;
   logic [1:0] ocl;
   logic new_word;
   logic [2:0] op;
   logic wd_en;
   logic wd_expire;
   logic clr;
   logic fault_any;
   logic [1:0] trip;
   logic [1:0] want;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [21:0] ocl_cycles(input logic [1:0] sel);
      if (sel == 2'h0) begin
         ocl_cycles = 22'(P_OCL_CYC0);
      end else if (sel == 2'h1) begin
         ocl_cycles = 22'(P_OCL_CYC1);
      end else if (sel == 2'h2) begin
         ocl_cycles = 22'(P_OCL_CYC2);
      end else begin
         ocl_cycles = 22'(P_OCL_CYC3);
      end
   endfunction

   function automatic logic [25:0] wd_cycles(input logic [1:0] sel);
      if (sel == 2'h0) begin
         wd_cycles = 26'(P_WD_CYC0);
      end else if (sel == 2'h1) begin
         wd_cycles = 26'(P_WD_CYC1);
      end else if (sel == 2'h2) begin
         wd_cycles = 26'(P_WD_CYC2);
      end else begin
         wd_cycles = 26'(P_WD_CYC3);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   ssf_spi_link u_link (
      .i_sclk(i_sclk),
      .i_cs_n(i_cs_n),
      .i_si(i_si),
      .o_so(o_so),
      .o_so_oe(o_so_oe),
      .i_rst_n(i_rst_n),
      .i_status(r.snap),
      .o_word(word),
      .o_word_tgl(word_tgl)
   );

   ////////////////////////////////////////////////////////////////////////////

   assign pins = {word_tgl, i_cs_n, i_fault_flag_n_in, i_supply_fault, i_over_temp,
                  i_low_trip_level, i_high_trip_level, i_failsafe_selector_in,
                  i_direct_control_in, i_wake};
   assign diff = r.p2 ^ r.p3;
   assign wake = r.pin[`SSF_PB_WAKE];
   assign failsafe_selector_in = r.pin[`SSF_PB_FSI +: 2];
   assign dir_in = r.pin[`SSF_PB_DIR +: 2];
   assign och = r.pin[`SSF_PB_OCH +: 2];
   assign ocl = r.pin[`SSF_PB_OCL +: 2];
   assign new_word = r.pin[`SSF_PB_TGL] != r.tgl_seen;
   assign op = word[7:5];
   assign fault_any = (|r.oc_flt) | (|r.ot_flt) | r.sup_flt;

   always_comb begin
      n = r;
      wd_en = 1'b0;
      wd_expire = 1'b0;
      clr = 1'b0;
      trip = 2'h0;
      want = 2'h0;
      // Three-stage capture; a change counts once stages two and three agree
      n.p1 = pins;
      n.p2 = r.p1;
      n.p3 = r.p2;
      n.pin = (~diff & r.p3) | (diff & r.pin);
      n.tgl_seen = r.pin[`SSF_PB_TGL];
      if (r.mode == SSF_SLEEP) begin
         n.mode = SSF_NORMAL;
      end
      // Command decode
      if (new_word) begin
         if (op == `SSF_OP_OUT) begin
            n.spi_on = word[1:0];
         end else if (op == `SSF_OP_DIR) begin
            n.dir_en = word[1:0];
            n.dir_inv = word[3:2];
         end else if (op == `SSF_OP_CURRENT_SENSE_OUT) begin
            n.cs_sel = word[0];
            n.cs_off = word[1];
         end else if (op == `SSF_OP_OC) begin
            n.ocl_sel = word[1:0];
            n.low_det = word[2];
         end else if (op == `SSF_OP_WD) begin
            n.wd_sel = word[1:0];
         end else if (op == `SSF_OP_CLR) begin
            clr = 1'b1;
         end
      end
      // Watchdog, restarted by every command word
      wd_en = wake && (failsafe_selector_in != `SSF_FSI_GND) && (r.mode == SSF_NORMAL);
      if (!wd_en || new_word) begin
         n.wd_cnt = 26'h0;
      end else if (r.wd_cnt >= wd_cycles(r.wd_sel) - 26'h1) begin
         wd_expire = 1'b1;
         n.wd_cnt = 26'h0;
      end else begin
         n.wd_cnt = r.wd_cnt + 26'h1;
      end
      if (wd_expire) begin
         n.mode = SSF_FAILSAFE;
         n.spi_on = `SSF_CFG_RST;
         n.dir_en = `SSF_CFG_RST;
         n.dir_inv = `SSF_CFG_RST;
         n.ocl_sel = `SSF_CFG_RST;
         n.wd_sel = `SSF_CFG_RST;
         n.low_det = 1'b0;
         n.cs_sel = 1'b0;
         n.cs_off = 1'b0;
      end
      if (r.mode == SSF_FAILSAFE && failsafe_selector_in == `SSF_FSI_GND) begin
         n.mode = SSF_NORMAL;
      end
      // Over-current blanking per channel
      for (int i = 0; i < 2; i++) begin
         case (r.ph[i])
            SSF_PH_OFF: begin
               if (r.hs[i]) begin
                  n.ph[i] = SSF_PH_HIGH;
                  n.oc_cnt[i] = 22'h0;
               end
            end
            SSF_PH_HIGH: begin
               trip[i] = och[i];
               n.oc_cnt[i] = r.oc_cnt[i] + 22'h1;
               if (r.oc_cnt[i] >= 22'(`SSF_OCH_CYC - 1)) begin
                  n.ph[i] = SSF_PH_LOW;
                  n.oc_cnt[i] = 22'h0;
               end
            end
            SSF_PH_LOW: begin
               trip[i] = och[i] | (r.low_det & ocl[i]);
               n.oc_cnt[i] = r.oc_cnt[i] + 22'h1;
               if (r.oc_cnt[i] >= ocl_cycles(r.ocl_sel) - 22'h1) begin
                  n.ph[i] = SSF_PH_STEADY;
               end
            end
            default: begin
               trip[i] = och[i] | ocl[i];
            end
         endcase
         if (!r.hs[i]) begin
            n.ph[i] = SSF_PH_OFF;
            n.oc_cnt[i] = 22'h0;
         end
      end
      // Latched faults; a new fault wins over a clear
      n.oc_flt = (r.oc_flt & {2{~clr}}) | trip;
      n.ot_flt = (r.ot_flt & {2{~clr}}) | r.pin[`SSF_PB_OT +: 2];
      n.sup_flt = (r.sup_flt & ~clr) | r.pin[`SSF_PB_SUP];
      // Output selection
      if (r.mode == SSF_FAILSAFE) begin
         if (failsafe_selector_in == `SSF_FSI_ON) begin
            want = 2'h3;
         end else if (failsafe_selector_in == `SSF_FSI_OUT0) begin
            want = 2'h1;
         end
      end else if (r.mode == SSF_NORMAL) begin
         for (int i = 0; i < 2; i++) begin
            want[i] = r.dir_en[i] ? (dir_in[i] ^ r.dir_inv[i]) : r.spi_on[i];
            want[i] = want[i] & ~(r.oc_flt[i] | r.ot_flt[i] | r.sup_flt);
         end
      end
      n.hs = want;
      // Status image frozen while the link is selected
      if (r.pin[`SSF_PB_CS]) begin
         n.snap = {r.pin[`SSF_PB_FFIN], r.mode == SSF_FAILSAFE, r.oc_flt, r.ot_flt,
                   r.sup_flt, wd_en};
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else if (i_ce) begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   assign o_power_output_zero = r.hs[0];
   assign o_power_output_one = r.hs[1];
   assign o_fault_flag_n_out = 1'b0;
   assign o_fault_flag_n_oe = fault_any;
   assign o_current_sense_sel = r.cs_sel;
   assign o_current_sense_oe = !r.cs_off && r.mode != SSF_SLEEP;
   assign o_sleep = r.mode == SSF_SLEEP;
   assign o_failsafe = r.mode == SSF_FAILSAFE;

   ////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence wd_fire_s;
      wd_expire && i_ce;
   endsequence

   sequence fs_held_s;
      r.mode == SSF_FAILSAFE && failsafe_selector_in != `SSF_FSI_GND;
   endsequence

   reset_defaults_a: assert property ($rose(i_rst_n) |-> o_sleep && !fault_any
      && r.spi_on == 2'h0 && r.dir_en == 2'h0)
      else $error("state not at defaults after reset");

   wd_count_a: assert property (wd_en && !new_word && !wd_expire && i_ce
      |=> r.wd_cnt == $past(r.wd_cnt) + 26'h1)
      else $error("watchdog not counting");

   wd_wake_a: assert property (!wake && i_ce |=> r.wd_cnt == 26'h0)
      else $error("watchdog counts without wake");

   flag_low_a: assert property ((|r.pin[`SSF_PB_OT +: 2] || r.pin[`SSF_PB_SUP]) && i_ce
      |=> o_fault_flag_n_oe && !o_fault_flag_n_out)
      else $error("fault flag not pulled low");

   flag_release_a: assert property (clr && trip == 2'h0 && r.pin[`SSF_PB_OT +: 2] == 2'h0
      && !r.pin[`SSF_PB_SUP] && i_ce |=> !o_fault_flag_n_oe)
      else $error("fault flag held after faults cleared");

   fs_outputs_a: assert property (wd_fire_s ##1 (fs_held_s and i_ce)
      |=> o_power_output_zero == (failsafe_selector_in != `SSF_FSI_OFF)
      && o_power_output_one == (failsafe_selector_in == `SSF_FSI_ON))
      else $error("fail-safe outputs wrong");

   fsi_ground_a: assert property (failsafe_selector_in == `SSF_FSI_GND && i_ce
      |=> !o_failsafe && r.wd_cnt == 26'h0)
      else $error("grounded selector left fail-safe active");

   current_sense_out_cfg_a: assert property (new_word && op == `SSF_OP_CURRENT_SENSE_OUT && i_ce
      |=> o_current_sense_sel == $past(word[0])
      && o_current_sense_oe == !$past(word[1]))
      else $error("current sense setting not applied");

   direct_in_a: assert property (r.mode == SSF_NORMAL && r.dir_en[0] && !fault_any
      && !wd_expire && i_ce |=> o_power_output_zero == $past(dir_in[0] ^ r.dir_inv[0]))
      else $error("direct input does not steer output zero");

   oc_high_a: assert property (r.ph[1] == SSF_PH_HIGH && och[1] && i_ce
      |=> r.oc_flt[1] ##1 !o_power_output_one)
      else $error("high trip not latched in high window");

   oc_blank_a: assert property (r.ph[0] == SSF_PH_HIGH && !och[0] && !r.oc_flt[0] && i_ce
      |=> !r.oc_flt[0] || $past(clr))
      else $error("low trip seen inside high window");

endmodule

// file: ssf_defs.svh
// Constants of the switch supervisor: timings, command codes, pin positions
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// System clock rate in kHz
`define SSF_CLK_KHZ 20000

// Over-current high blanking time, in us, and its count
`define SSF_T_OCH_US 10
`define SSF_OCH_CYC (`SSF_T_OCH_US * `SSF_CLK_KHZ / 1000)

// Over-current low blanking times, in us (selector 0..3)
`define SSF_T_OCL0_US 155000
`define SSF_T_OCL1_US 10000
`define SSF_T_OCL2_US 1200
`define SSF_T_OCL3_US 150

// Watchdog timeouts, in ms (selector 0..3)
`define SSF_T_WD0_MS 620
`define SSF_T_WD1_MS 310
`define SSF_T_WD2_MS 2500
`define SSF_T_WD3_MS 1250

// Command opcodes, bits 7:5 of a command word
`define SSF_OP_OUT 3'h0
`define SSF_OP_DIR 3'h1
`define SSF_OP_CURRENT_SENSE_OUT 3'h2
`define SSF_OP_OC 3'h3
`define SSF_OP_WD 3'h4
`define SSF_OP_CLR 3'h5

// Fail-safe selector codes
`define SSF_FSI_GND 2'h0
`define SSF_FSI_OFF 2'h1
`define SSF_FSI_ON 2'h2
`define SSF_FSI_OUT0 2'h3

// Reset values
`define SSF_CFG_RST 2'h0
`define SSF_SNAP_RST 8'h00

// Positions in the synchronised input vector
`define SSF_PIN_W 15
`define SSF_PB_WAKE 0
`define SSF_PB_DIR 1
`define SSF_PB_FSI 3
`define SSF_PB_OCH 5
`define SSF_PB_OCL 7
`define SSF_PB_OT 9
`define SSF_PB_SUP 11
`define SSF_PB_FFIN 12
`define SSF_PB_CS 13
`define SSF_PB_TGL 14

`endif

// file: ssf_host.sv
// Host model: serial master that sends command frames and collects status
`timescale 1ns/1ps
module ssf_host (
   // Link pins
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_si,
   input wire logic i_so,
   input wire logic i_so_oe
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One 8-bit frame, serial clock still outside it
   task automatic xfer(input logic [7:0] cmd, output logic [7:0] rsp);
      o_cs_n = 1'b0;
      #250;
      for (int i = 7; i >= 0; i--) begin
         o_si = cmd[i];
         #3;
         rsp[i] = i_so_oe ? i_so : 1'bx;
         o_sclk = 1'b1;
         #3;
         o_sclk = 1'b0;
      end
      o_si = 1'b0;
      #3;
      o_cs_n = 1'b1;
      #500;
   endtask
endmodule

// file: ssf_pkg.sv
// Types of the switch supervisor
package ssf_pkg;

   typedef enum logic [1:0] {SSF_SLEEP, SSF_NORMAL, SSF_FAILSAFE} ssf_mode_t;

   typedef enum logic [1:0] {SSF_PH_OFF, SSF_PH_HIGH, SSF_PH_LOW, SSF_PH_STEADY} ssf_ocph_t;

   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] sh_in;
      logic [6:0] sh_out;
      logic [7:0] word;
      logic tgl;
   } ssf_link_t;

   typedef struct packed {
      logic [14:0] p1;
      logic [14:0] p2;
      logic [14:0] p3;
      logic [14:0] pin;
      ssf_mode_t mode;
      logic tgl_seen;
      logic [1:0] spi_on;
      logic [1:0] dir_en;
      logic [1:0] dir_inv;
      logic cs_sel;
      logic cs_off;
      logic [1:0] ocl_sel;
      logic low_det;
      logic [1:0] wd_sel;
      logic [25:0] wd_cnt;
      logic [1:0] oc_flt;
      logic [1:0] ot_flt;
      logic sup_flt;
      logic [7:0] snap;
      ssf_ocph_t [1:0] ph;
      logic [1:0][21:0] oc_cnt;
      logic [1:0] hs;
   } ssf_state_t;

endpackage

// file: ssf_spi_link.sv
// Serial command receiver and status shifter on the serial clock
`timescale 1ns/1ps
module ssf_spi_link
   import ssf_pkg::*;
(
   // Link pins
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   // Reset
   input wire logic i_rst_n,
   // System side
   input wire logic [7:0] i_status,
   output logic [7:0] o_word,
   output logic o_word_tgl
);

   ssf_link_t r;
   ssf_link_t n;

   always_comb begin
      n = r;
      if (!i_cs_n) begin
         n.cnt = r.cnt + 3'h1;
         n.sh_in = {r.sh_in[5:0], i_si};
         if (r.cnt == 3'h0) begin
            n.sh_out = i_status[6:0];
         end else begin
            n.sh_out = {r.sh_out[5:0], 1'b0};
         end
         if (r.cnt == 3'h7) begin
            n.word = {r.sh_in, i_si};
            n.tgl = ~r.tgl;
         end
      end
   end

   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Status bits leave MSB first, new bit after each rising edge
   assign o_so = (r.cnt == 3'h0) ? i_status[7] : r.sh_out[6];
   assign o_so_oe = !i_cs_n;
   assign o_word = r.word;
   assign o_word_tgl = r.tgl;

endmodule

// file: tb_top.sv
// Self-checking bench of the switch supervisor
`timescale 1ns/1ps
module tb_top;
   import ssf_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic wake = 1'b0;
   logic [1:0] dir_in = 2'h0;
   logic [1:0] failsafe_selector_in = 2'h1;
   logic [1:0] low_trip = 2'h0;
   logic [1:0] over_temp = 2'h0;
   logic ce = 1'b1;
   logic [1:0] high_trip = 2'h0;
   logic supply = 1'b0;
   logic sclk, cs_n, si, so, so_oe, flag_out, flag_oe, flag_n;
   logic hs0, hs1, cs_sel, cs_oe, sleep, failsafe;
   logic [7:0] rsp;
   int miscompares = 0;
   int check_count = 0;
   always #25 i_clk = ~i_clk;
   assign flag_n = flag_oe ? flag_out : 1'b1;
   ssf_ctrl #(.P_OCL_CYC3(100), .P_WD_CYC0(200), .P_WD_CYC1(100)) uut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
      .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe),
      .i_wake(wake), .i_direct_control_in(dir_in), .i_failsafe_selector_in(failsafe_selector_in),
      .i_high_trip_level(high_trip), .i_low_trip_level(low_trip), .i_over_temp(over_temp),
      .i_supply_fault(supply), .i_fault_flag_n_in(flag_n), .o_fault_flag_n_out(flag_out),
      .o_fault_flag_n_oe(flag_oe), .o_power_output_zero(hs0), .o_power_output_one(hs1),
      .o_current_sense_sel(cs_sel), .o_current_sense_oe(cs_oe), .o_sleep(sleep),
      .o_failsafe(failsafe));
   ssf_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic cmd(input logic [7:0] c);
      host.xfer(c, rsp);
      tick(1);
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic do_reset;
      @(posedge i_clk) i_rst_n <= 1'b0;
      tick(8);
      check({4'h0, sleep, hs1, hs0, cs_oe}, 8'h08);
      check(8'(flag_oe), 8'h00);
      @(posedge i_clk) i_rst_n <= 1'b1;
      tick(100);
      check({6'h00, sleep, cs_oe}, 8'h01);
   endtask
   task automatic t_direct;
      cmd(8'h23);
      for (int v = 0; v < 4; v++) begin
         @(posedge i_clk) dir_in <= 2'(v);
         tick(8);
         check({6'h00, hs1, hs0}, 8'(v));
      end
      cmd(8'h27);
      for (int v = 0; v < 4; v++) begin
         @(posedge i_clk) dir_in <= 2'(v);
         tick(8);
         check({6'h00, hs1, hs0}, 8'(v ^ 1));
      end
      cmd(8'h20);
      check({6'h00, hs1, hs0}, 8'h00);
   endtask
   task automatic t_sense;
      logic [7:0] c [3] = '{8'h41, 8'h42, 8'h40};
      logic [7:0] e [3] = '{8'h03, 8'h00, 8'h02};
      for (int k = 0; k < 3; k++) begin
         cmd(c[k]);
         check({6'h00, cs_oe, cs_sel}, e[k]);
      end
   endtask
   task automatic t_fault;
      @(posedge i_clk) over_temp <= 2'h1;
      tick(8);
      check({6'h00, flag_oe, flag_n}, 8'h02);
      host.xfer(8'hE0, rsp);
      check(rsp, 8'h04);
      check(8'(so_oe), 8'h00);
      @(posedge i_clk) over_temp <= 2'h0;
      tick(8);
      check(8'(flag_oe), 8'h01);
      cmd(8'hA0);
      check({6'h00, flag_oe, flag_n}, 8'h01);
   endtask
   task automatic t_ocp;
      for (int k = 0; k < 2; k++) begin
         cmd(k == 1 ? 8'h67 : 8'h63);
         @(posedge i_clk) low_trip <= 2'h1;
         cmd(8'h01);
         check({6'h00, flag_oe, hs0}, 8'h01);
         tick(150);
         check(8'(flag_oe), 8'h00);
         tick(100);
         check(8'(flag_oe), 8'(k));
         tick(70);
         check({6'h00, flag_oe, hs0}, 8'h02);
         @(posedge i_clk) low_trip <= 2'h0;
         cmd(8'h00);
         cmd(8'hA0);
         check(8'(flag_oe), 8'h00);
      end
   endtask
   task automatic t_watchdog;
      logic [7:0] e [4] = '{8'h00, 8'h00, 8'h03, 8'h01};
      for (int c = 1; c < 4; c++) begin
         @(posedge i_clk) failsafe_selector_in <= 2'(c);
         wake <= 1'b1;
         do_reset;
         tick(50);
         check(8'(failsafe), 8'h00);
         tick(90);
         check({5'h00, failsafe, hs1, hs0}, 8'h04 | e[c]);
      end
      @(posedge i_clk) failsafe_selector_in <= 2'h0;
      tick(10);
      check(8'(failsafe), 8'h00);
      tick(400);
      check(8'(failsafe), 8'h00);
      @(posedge i_clk) failsafe_selector_in <= 2'h1;
      wake <= 1'b0;
      do_reset;
      tick(400);
      check(8'(failsafe), 8'h00);
      @(posedge i_clk) wake <= 1'b1;
      tick(150);
      check(8'(failsafe), 8'h00);
      tick(90);
      check(8'(failsafe), 8'h01);
   endtask
   task automatic t_trip;
      @(posedge i_clk) high_trip <= 2'h2;
      cmd(8'h02);
      check({6'h00, flag_oe, hs1}, 8'h02);
      host.xfer(8'hE0, rsp);
      check(rsp, 8'h20);
      @(posedge i_clk) high_trip <= 2'h0;
      cmd(8'h00);
      cmd(8'hA0);
      check(8'(flag_oe), 8'h00);
      @(posedge i_clk) supply <= 1'b1;
      tick(8);
      check(8'(flag_oe), 8'h01);
      host.xfer(8'hE0, rsp);
      check(rsp, 8'h02);
      @(posedge i_clk) supply <= 1'b0;
      cmd(8'hA0);
      check(8'(flag_oe), 8'h00);
   endtask
   task automatic t_wd_sel;
      do_reset;
      cmd(8'h81);
      tick(60);
      check(8'(failsafe), 8'h00);
      tick(60);
      check(8'(failsafe), 8'h01);
   endtask
   task automatic t_enable;
      do_reset;
      tick(50);
      @(posedge i_clk) ce <= 1'b0;
      tick(100);
      check(8'(failsafe), 8'h00);
      @(posedge i_clk) ce <= 1'b1;
      tick(90);
      check(8'(failsafe), 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial begin
      do_reset;
      t_direct;
      t_sense;
      t_fault;
      t_ocp;
      t_trip;
      t_watchdog;
      t_wd_sel;
      t_enable;
      complete_run;
   end
   initial begin
      #500000;
      miscompares++;
      complete_run;
   end
endmodule
